/* logic/dhec_ctrl.sv */
// debug halt, wake-up, event cause and identification logic
//
// Functional notes
// R01: debugger halt wakes core from sleep; deep sleep only as in R02
// R02: deep-sleep wake only over two-wire port
// R03: two-wire port: clock plus shared data
// R04: external halt request halts; report stopped
// R05: debug bits survive warm reset when registered
// R06: unregistered tool: system reset clears debug
// R07: warm reset leaves debug logic unchanged; here only while pwr_ack is set, else warm reset clears it
// R08: power-on reset clears whole debug system
// R09: power-up request answered by acknowledge
// R10: interrupt mask in debug suppresses interrupts
// R11: halt entry only with halting debug enabled
// R12: breakpoints, vector catch, step are synchronous
// R13: watchpoint, halt bit, external are asynchronous
// R14: synchronous events win over asynchronous ones
// R15: one cause bit per event, write-one-clears
// R16: cause bits set even if event ignored
// R17: writes need key in upper halfword; here only halt control writes check it, cause and power-up writes need none
// R18: debug clock is free-running system clock
// R19: always-on, no power-save modes
// R20: boundary-scan and port identity codes readable
// R21: ident byte1 jep low, part high
// R22: ident byte2 revision, one, jep high
// R23: ident bytes 3 and 4 read zero
// R24: stopped output held while halted
`timescale 1ns/1ns
module dhec_ctrl #(
	parameter logic [31:0] JTAG_ID = dhec_pkg::DHEC_JTAG_ID_DEF,
	parameter logic [31:0] DP_ID = dhec_pkg::DHEC_DP_ID_DEF,
	parameter logic [11:0] PART_NUM = dhec_pkg::DHEC_PART_DEF,
	parameter logic [6:0] JEP_CODE = dhec_pkg::DHEC_JEP_DEF,
	parameter logic [3:0] REVISION = dhec_pkg::DHEC_REV_DEF
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic warm_reset_n,
	input wire logic swclk,
	input wire logic swdio_in,
	output logic swdio_out,
	output logic swdio_oe_n,
	input wire logic external_halt_request,
	input wire logic ap_req,
	input wire logic ap_we,
	input wire logic [11:0] ap_addr,
	input wire logic [31:0] ap_wdata,
	output logic ap_ack,
	output logic [31:0] ap_rdata,
	input wire dhec_pkg::dhec_core_ev_t core_ev,
	input wire dhec_pkg::dhec_core_st_t core_st,
	output logic halt_req,
	output logic core_stopped,
	output logic wake_event,
	output logic interrupt_mask_in_debug
);

	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a[11:2] == ofs[11:2]);
	endfunction : hit

	// synchronised pins; data inverted so the reset level matches its idle high
	logic [2:0] pin_q;
	logic swclk_s;
	logic swdio_s;
	logic ext_s;
	logic swclk_d;
	logic swdio_d;

	// R03 clock and data pins synchronised
	dhec_sync #(.W(3)) u_sync (
		.clk(clk),
		.rst(rst),
		.d({swclk, ~swdio_in, external_halt_request}),
		.q(pin_q)
	);
	assign swclk_s = pin_q[2];
	assign swdio_s = ~pin_q[1];
	assign ext_s = pin_q[0];

	// registers
	logic pwr_req;
	logic pwr_ack;
	logic two_wire_seen;
	logic one_pin_seen;
	logic debug_en;
	logic c_halt;
	logic c_step;
	logic mask_ints;
	logic [4:0] cause;
	dhec_pkg::dhec_halt_st_t st;
	dhec_pkg::dhec_halt_st_t next_st;

	// R05 R06 R07 debug reset domain
	wire dbg_rst = rst | (~warm_reset_n & ~pwr_ack);

	// access decode
	wire wr = ap_req & ap_we;
	wire wr_hcs = wr & hit(ap_addr, dhec_pkg::DHEC_OFS_HCS);
	wire wr_cause = wr & hit(ap_addr, dhec_pkg::DHEC_OFS_CAUSE);
	wire wr_pwr = wr & hit(ap_addr, dhec_pkg::DHEC_OFS_PWR);
	// R17 key check on control writes
	wire key_ok = ap_wdata[dhec_pkg::DHEC_HCS_KEY_LSB +: 16] == dhec_pkg::DHEC_KEY;
	wire hcs_load = wr_hcs & key_ok;

	// R12 synchronous event group
	wire sync_any = core_ev.breakpoint_instruction_instr | core_ev.bp_match | core_ev.vcatch
		| core_ev.step_done;
	// R13 asynchronous event group
	wire async_any = core_ev.wp_match | c_halt | ext_s;

	// R14 synchronous set masks asynchronous set
	logic [4:0] set_sync;
	logic [4:0] set_async;
	logic [4:0] cause_set;
	assign set_sync = {1'b0, core_ev.vcatch, 1'b0,
		core_ev.breakpoint_instruction_instr | core_ev.bp_match, core_ev.step_done};
	assign set_async = {ext_s, 1'b0, core_ev.wp_match, 1'b0, c_halt};
	assign cause_set = sync_any ? set_sync : set_async;

	// R15 R16 write-one-clear, set wins
	logic [4:0] next_cause;
	assign next_cause = (cause & ~(wr_cause ? ap_wdata[4:0] : 5'h00)) | cause_set;

	// R11 halt only when enabled
	wire halt_cause = debug_en & (sync_any | async_any);

	always_comb begin
		next_st = st;
		case (st)
			dhec_pkg::DHEC_RUN: begin
				if (halt_cause)
					next_st = dhec_pkg::DHEC_REQ;
			end
			dhec_pkg::DHEC_REQ: begin
				if (!debug_en)
					next_st = dhec_pkg::DHEC_RUN;
				else if (core_st.halted)
					next_st = dhec_pkg::DHEC_HALTED;
			end
			dhec_pkg::DHEC_HALTED: begin
				if (!core_st.halted)
					next_st = dhec_pkg::DHEC_RUN;
			end
			default: next_st = dhec_pkg::DHEC_RUN;
		endcase
	end

	// R01 any sleep woken; R02 deep only over two-wire
	wire wake_ok = core_st.sleeping | (core_st.deep_sleep & two_wire_seen);
	wire next_wake = (next_st == dhec_pkg::DHEC_REQ) & wake_ok;
	// R04 external request kept pending through halt
	wire next_halt_req = (next_st == dhec_pkg::DHEC_REQ)
		| ((next_st == dhec_pkg::DHEC_HALTED) & debug_en & (c_halt | ext_s));

	// read mux
	logic [31:0] hcs_rd;
	logic [31:0] pwr_rd;
	logic [7:0] rom0;
	logic [7:0] rom1;
	logic [7:0] rom2;
	logic [31:0] rd_word;
	assign hcs_rd = {13'h0, core_st.deep_sleep | core_st.sleeping,
		st == dhec_pkg::DHEC_HALTED, 1'b1,
		12'h000, mask_ints, c_step, c_halt, debug_en};
	assign pwr_rd = {28'h0000000, one_pin_seen, two_wire_seen, pwr_ack, pwr_req};
	// R21 byte0 and byte1 layout
	assign rom0 = PART_NUM[7:0];
	assign rom1 = {JEP_CODE[3:0], PART_NUM[11:8]};
	// R22 byte2 layout with fixed one
	assign rom2 = {REVISION, 1'b1, JEP_CODE[6:4]};
	// R20 R23 identity words and zero bytes
	assign rd_word =
		hit(ap_addr, dhec_pkg::DHEC_OFS_CAUSE) ? {27'h0, cause} :
		hit(ap_addr, dhec_pkg::DHEC_OFS_HCS) ? hcs_rd :
		hit(ap_addr, dhec_pkg::DHEC_OFS_PWR) ? pwr_rd :
		hit(ap_addr, dhec_pkg::DHEC_OFS_JTAG_ID) ? JTAG_ID :
		hit(ap_addr, dhec_pkg::DHEC_OFS_DP_ID) ? DP_ID :
		hit(ap_addr, dhec_pkg::DHEC_OFS_ROM0) ? {24'h000000, rom0} :
		hit(ap_addr, dhec_pkg::DHEC_OFS_ROM1) ? {24'h000000, rom1} :
		hit(ap_addr, dhec_pkg::DHEC_OFS_ROM2) ? {24'h000000, rom2} :
		hit(ap_addr, dhec_pkg::DHEC_OFS_ROM3) ? {24'h000000, dhec_pkg::DHEC_ROM3_VAL} :
		hit(ap_addr, dhec_pkg::DHEC_OFS_ROM4) ? {24'h000000, dhec_pkg::DHEC_ROM4_VAL} :
		32'h00000000;

	// R08 R09 port domain, cleared by power-on only
	always_ff @(posedge clk) begin
		if (rst) begin
			pwr_req <= 1'b0;
			pwr_ack <= 1'b0;
		end else begin
			if (wr_pwr)
				pwr_req <= ap_wdata[dhec_pkg::DHEC_PWR_REQ];
			pwr_ack <= pwr_req;
		end
	end

	// R03 link kind from edges of synchronised pins
	always_ff @(posedge clk) begin
		if (rst) begin
			swclk_d <= 1'b0;
			swdio_d <= 1'b1;
			two_wire_seen <= 1'b0;
			one_pin_seen <= 1'b0;
		end else begin
			swclk_d <= swclk_s;
			swdio_d <= swdio_s;
			if (swclk_s & ~swclk_d)
				two_wire_seen <= 1'b1;
			if ((swdio_s ^ swdio_d) & ~two_wire_seen & ~swclk_s)
				one_pin_seen <= 1'b1;
		end
	end

	// R05 R07 control bits in the debug domain
	always_ff @(posedge clk) begin
		if (dbg_rst) begin
			{mask_ints, c_step, c_halt, debug_en} <= dhec_pkg::DHEC_HCS_RST;
		end else if (hcs_load) begin
			debug_en <= ap_wdata[dhec_pkg::DHEC_HCS_EN];
			c_halt <= ap_wdata[dhec_pkg::DHEC_HCS_HALT];
			c_step <= ap_wdata[dhec_pkg::DHEC_HCS_STEP];
			mask_ints <= ap_wdata[dhec_pkg::DHEC_HCS_MASK];
		end
	end

	always_ff @(posedge clk) begin
		if (dbg_rst) begin
			cause <= dhec_pkg::DHEC_CAUSE_RST;
			st <= dhec_pkg::DHEC_RUN;
		end else begin
			cause <= next_cause;
			st <= next_st;
		end
	end

	// R04 R24 halt outputs; R10 mask only while enabled
	always_ff @(posedge clk) begin
		if (dbg_rst) begin
			halt_req <= 1'b0;
			core_stopped <= 1'b0;
			wake_event <= 1'b0;
			interrupt_mask_in_debug <= 1'b0;
		end else begin
			halt_req <= next_halt_req;
			core_stopped <= next_st == dhec_pkg::DHEC_HALTED;
			wake_event <= next_wake;
			interrupt_mask_in_debug <= debug_en & mask_ints;
		end
	end

	// bit-level serial protocol lives elsewhere; pad is released here
	always_ff @(posedge clk) begin
		if (rst) begin
			ap_ack <= 1'b0;
			ap_rdata <= 32'h00000000;
			swdio_out <= 1'b0;
			swdio_oe_n <= 1'b1;
		end else begin
			ap_ack <= ap_req;
			ap_rdata <= ap_req & ~ap_we ? rd_word : 32'h00000000;
			swdio_out <= 1'b0;
			swdio_oe_n <= 1'b1;
		end
	end

	// R18 R19 no gating: every flop runs on clk at all times

	property p_wake_sleep;
		@(posedge clk) disable iff (dbg_rst)
		(st == dhec_pkg::DHEC_RUN && halt_cause && core_st.sleeping) |=> wake_event;
	endproperty
	a_wake_sleep: assert property (p_wake_sleep) else $error("no wake"); // R01

	property p_deep_one_pin;
		@(posedge clk) disable iff (rst)
		(!two_wire_seen && !core_st.sleeping) |=> !wake_event;
	endproperty
	a_deep_one_pin: assert property (p_deep_one_pin) else $error("deep wake"); // R02

	property p_ext_halt;
		@(posedge clk) disable iff (dbg_rst)
		(debug_en && ext_s && st == dhec_pkg::DHEC_RUN && !hcs_load) |=> halt_req;
	endproperty
	a_ext_halt: assert property (p_ext_halt) else $error("ext no halt"); // R04

	property p_stopped;
		@(posedge clk) disable iff (dbg_rst)
		(st == dhec_pkg::DHEC_REQ && debug_en && core_st.halted) |=> core_stopped;
	endproperty
	a_stopped: assert property (p_stopped) else $error("stopped missing"); // R24

	property p_warm_keep;
		@(posedge clk) disable iff (rst)
		(!warm_reset_n && pwr_ack && !hcs_load) |=> $stable(debug_en);
	endproperty
	a_warm_keep: assert property (p_warm_keep) else $error("warm cleared"); // R05

	property p_warm_clear;
		@(posedge clk) disable iff (rst)
		(!warm_reset_n && !pwr_ack) |=> (!debug_en && cause == 5'h00);
	endproperty
	a_warm_clear: assert property (p_warm_clear) else $error("not cleared"); // R06

	property p_ack;
		@(posedge clk) disable iff (rst)
		pwr_req |=> pwr_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("no ack"); // R09

	property p_mask;
		@(posedge clk) disable iff (dbg_rst)
		interrupt_mask_in_debug |-> $past(debug_en && mask_ints);
	endproperty
	a_mask: assert property (p_mask) else $error("mask wrong"); // R10

	property p_disabled;
		@(posedge clk) disable iff (dbg_rst)
		(!debug_en && st == dhec_pkg::DHEC_RUN) |=> !halt_req;
	endproperty
	a_disabled: assert property (p_disabled) else $error("halt disabled"); // R11

	property p_prio;
		@(posedge clk) disable iff (dbg_rst)
		(core_ev.breakpoint_instruction_instr && core_ev.wp_match && !wr_cause && cause == 5'h00)
		|=> cause == 5'h02;
	endproperty
	a_prio: assert property (p_prio) else $error("async won"); // R14

	property p_w1c;
		@(posedge clk) disable iff (dbg_rst)
		(wr_cause && ap_wdata[0] && !cause_set[0]) |=> !cause[0];
	endproperty
	a_w1c: assert property (p_w1c) else $error("w1c fail"); // R15

	property p_ignored;
		@(posedge clk) disable iff (dbg_rst)
		(!debug_en && core_ev.vcatch) |=> cause[dhec_pkg::DHEC_CA_VCATCH];
	endproperty
	a_ignored: assert property (p_ignored) else $error("ignored lost"); // R16

	property p_rom2;
		@(posedge clk) disable iff (rst)
		(ap_req && !ap_we && hit(ap_addr, dhec_pkg::DHEC_OFS_ROM2)) |=> ap_rdata[3];
	endproperty
	a_rom2: assert property (p_rom2) else $error("rom2 bit3"); // R22

endmodule : dhec_ctrl

/* logic/dhec_pkg.sv */
// constants, types and register map of the debug halt and event control block
package dhec_pkg;

	// register byte offsets on the debug access port
	localparam logic [11:0] DHEC_OFS_CAUSE = 12'hD30;
	localparam logic [11:0] DHEC_OFS_HCS = 12'hDF0;
	localparam logic [11:0] DHEC_OFS_PWR = 12'hF00;
	localparam logic [11:0] DHEC_OFS_JTAG_ID = 12'hF08;
	localparam logic [11:0] DHEC_OFS_DP_ID = 12'hF0C;
	localparam logic [11:0] DHEC_OFS_ROM4 = 12'hFD0;
	localparam logic [11:0] DHEC_OFS_ROM0 = 12'hFE0;
	localparam logic [11:0] DHEC_OFS_ROM1 = 12'hFE4;
	localparam logic [11:0] DHEC_OFS_ROM2 = 12'hFE8;
	localparam logic [11:0] DHEC_OFS_ROM3 = 12'hFEC;

	// halt_control_status_reg fields
	localparam int DHEC_HCS_EN = 0;
	localparam int DHEC_HCS_HALT = 1;
	localparam int DHEC_HCS_STEP = 2;
	localparam int DHEC_HCS_MASK = 3;
	localparam int DHEC_HCS_KEY_LSB = 16;
	localparam int DHEC_HCS_S_REGRDY = 16;
	localparam int DHEC_HCS_S_HALT = 17;
	localparam int DHEC_HCS_S_SLEEP = 18;
	localparam logic [15:0] DHEC_KEY = 16'hA05F;
	localparam logic [3:0] DHEC_HCS_RST = 4'h0;

	// debug_event_cause_reg fields
	localparam int DHEC_CAUSE_W = 5;
	localparam int DHEC_CA_HALTED = 0;
	localparam int DHEC_CA_BREAKPOINT_INSTRUCTION = 1;
	localparam int DHEC_CA_DWT = 2;
	localparam int DHEC_CA_VCATCH = 3;
	localparam int DHEC_CA_EXT = 4;
	localparam logic [4:0] DHEC_CAUSE_RST = 5'h00;

	// power-up register fields
	localparam int DHEC_PWR_REQ = 0;
	localparam int DHEC_PWR_ACK = 1;
	localparam int DHEC_PWR_TWO_WIRE = 2;
	localparam int DHEC_PWR_ONE_PIN = 3;

	// identification defaults, values arbitrary
	localparam logic [31:0] DHEC_JTAG_ID_DEF = 32'h1000_0001;
	localparam logic [31:0] DHEC_DP_ID_DEF = 32'h2000_0001;
	localparam logic [11:0] DHEC_PART_DEF = 12'h0A5;
	localparam logic [6:0] DHEC_JEP_DEF = 7'h11;
	localparam logic [3:0] DHEC_REV_DEF = 4'h1;
	localparam logic [7:0] DHEC_ROM3_VAL = 8'h00;
	localparam logic [7:0] DHEC_ROM4_VAL = 8'h00;

	typedef struct packed {
		logic breakpoint_instruction_instr;
		logic bp_match;
		logic vcatch;
		logic step_done;
		logic wp_match;
	} dhec_core_ev_t;

	typedef struct packed {
		logic sleeping;
		logic deep_sleep;
		logic halted;
	} dhec_core_st_t;

	typedef enum logic [1:0] {
		DHEC_RUN = 2'b00,
		DHEC_REQ = 2'b01,
		DHEC_HALTED = 2'b11
	} dhec_halt_st_t;

endpackage : dhec_pkg

/* logic/dhec_sync.sv */
// two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ns
module dhec_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end

endmodule : dhec_sync

/* verification/dhec_probe.sv */
// debug probe model: serial clock and data line seen from the external host
`timescale 1ns/1ns
module dhec_probe (
	input wire logic swdio_out,
	input wire logic swdio_oe_n,
	output logic swclk,
	output wire logic swdio
);
	logic drv_en = 1'b0;
	logic drv_val = 1'b1;
	// released line floats to the pull-up, never to the last bit
	assign swdio = !swdio_oe_n ? swdio_out : (drv_en ? drv_val : 1'b1);
	initial begin
		swclk = 1'b0;
	end
	task automatic two_wire_frame(input int bits);
		for (int i = 0; i < bits; i++) begin
			drv_en = 1'b1;
			drv_val = i[0];
			#40;
			swclk = 1'b1;
			#40;
			swclk = 1'b0;
		end
		drv_en = 1'b0;
	endtask : two_wire_frame
	task automatic one_pin_frame(input int bits);
		for (int i = 0; i < bits; i++) begin
			drv_en = 1'b1;
			drv_val = ~drv_val;
			#80;
		end
		drv_en = 1'b0;
	endtask : one_pin_frame
endmodule : dhec_probe

/* verification/tb_top.sv */
// self-checking bench of the debug halt and event control block
`timescale 1ns/1ns
module tb_top;
	localparam logic [11:0] PN = dhec_pkg::DHEC_PART_DEF;
	localparam logic [6:0] JP = dhec_pkg::DHEC_JEP_DEF;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic warm_reset_n = 1'b1;
	logic ext_hr = 1'b0;
	logic ap_req = 1'b0;
	logic ap_we = 1'b0;
	logic [11:0] ap_addr = 12'h000;
	logic [31:0] ap_wdata = 32'h0000_0000;
	dhec_pkg::dhec_core_ev_t core_ev = 5'h00;
	dhec_pkg::dhec_core_st_t core_st = 3'h0;
	logic swclk, swdio, swdio_out, swdio_oe_n, ap_ack, halt_req, core_stopped, wake_event, imask;
	logic [31:0] ap_rdata;
	logic [31:0] q;
	int error_cnt = 0;
	int comparisons = 0;
	wire [3:0] mon = {ap_ack, wake_event, core_stopped, halt_req};

	initial begin
		forever #4 clk = ~clk;
	end

	dhec_probe dhec_probe_i (.swdio_out(swdio_out), .swdio_oe_n(swdio_oe_n), .swclk(swclk),
		.swdio(swdio));
	dhec_ctrl dhec_ctrl_i (.clk(clk), .rst(rst), .warm_reset_n(warm_reset_n), .swclk(swclk),
		.swdio_in(swdio), .swdio_out(swdio_out), .swdio_oe_n(swdio_oe_n),
		.external_halt_request(ext_hr), .ap_req(ap_req), .ap_we(ap_we), .ap_addr(ap_addr),
		.ap_wdata(ap_wdata), .ap_ack(ap_ack), .ap_rdata(ap_rdata), .core_ev(core_ev),
		.core_st(core_st), .halt_req(halt_req), .core_stopped(core_stopped),
		.wake_event(wake_event), .interrupt_mask_in_debug(imask));

	task automatic finish_test;
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	// one word per request, answer taken one edge later
	task automatic acc(input logic we, input logic [11:0] a, input logic [31:0] d);
		cyc(1);
		{ap_req, ap_we, ap_addr, ap_wdata} = {1'b1, we, a, d};
		cyc(1);
		q = ap_rdata;
		ap_req = 1'b0;
	endtask : acc
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
		acc(1'b0, a, 32'h0000_0000);
		chk(nm, q, exp);
		chk("ap_ack", ap_ack, 32'h1);
	endtask : rd
	task automatic hcs(input logic [3:0] b);
		acc(1'b1, dhec_pkg::DHEC_OFS_HCS, {dhec_pkg::DHEC_KEY, 12'h000, b});
	endtask : hcs
	task automatic wait_on(input int sel);
		int i;
		for (i = 0; i < 20 && mon[sel] !== 1'b1; i++) cyc(1);
		if (i == 20) begin
			error_cnt++;
			$display("MISMATCH wait expected 1 seen 0");
			finish_test();
		end
	endtask : wait_on

	task automatic t_ident;
		rd(dhec_pkg::DHEC_OFS_JTAG_ID, dhec_pkg::DHEC_JTAG_ID_DEF, "jtag_id");
		rd(dhec_pkg::DHEC_OFS_DP_ID, dhec_pkg::DHEC_DP_ID_DEF, "dp_id");
		acc(1'b1, dhec_pkg::DHEC_OFS_ROM0, 32'hFFFF_FFFF);
		rd(dhec_pkg::DHEC_OFS_ROM0, {24'h000000, PN[7:0]}, "rom0");
		rd(dhec_pkg::DHEC_OFS_ROM1, {24'h000000, JP[3:0], PN[11:8]}, "rom1");
		rd(dhec_pkg::DHEC_OFS_ROM2, {24'h000000, dhec_pkg::DHEC_REV_DEF, 1'b1, JP[6:4]}, "rom2");
		rd(dhec_pkg::DHEC_OFS_ROM3, 32'h0000_0000, "rom3");
		rd(dhec_pkg::DHEC_OFS_ROM4, 32'h0000_0000, "rom4");
		rd(12'hD34, 32'h0000_0000, "unmapped");
		acc(1'b1, dhec_pkg::DHEC_OFS_HCS, 32'h0000_0001);
		rd(dhec_pkg::DHEC_OFS_HCS, 32'h0001_0000, "hcs_nokey");
	endtask : t_ident
	task automatic t_events;
		logic [4:0] ex [5] = '{5'h04, 5'h01, 5'h08, 5'h02, 5'h02};
		for (int i = 0; i < 5; i++) begin
			core_ev = 5'h01 << i;
			cyc(1);
			core_ev = 5'h00;
			cyc(2);
			chk("halt_req_off", halt_req, 32'h0);
			rd(dhec_pkg::DHEC_OFS_CAUSE, ex[i], "cause");
			acc(1'b1, dhec_pkg::DHEC_OFS_CAUSE, 32'h0000_001F);
			rd(dhec_pkg::DHEC_OFS_CAUSE, 32'h0000_0000, "cause_clr");
		end
	endtask : t_events
	task automatic t_halt;
		acc(1'b1, dhec_pkg::DHEC_OFS_PWR, 32'h0000_0001);
		rd(dhec_pkg::DHEC_OFS_PWR, 32'h0000_0003, "pwr_ack");
		hcs(4'h1);
		core_st = 3'h4;
		hcs(4'h3);
		wait_on(0);
		cyc(1);
		chk("wake", wake_event, 32'h1);
		core_st = 3'h1;
		wait_on(1);
		cyc(5);
		chk("stopped", core_stopped, 32'h1);
		rd(dhec_pkg::DHEC_OFS_HCS, 32'h0003_0003, "hcs_halted");
		hcs(4'h1);
		core_st = 3'h0;
		cyc(2);
		chk("stopped_off", core_stopped, 32'h0);
		chk("halt_req_off", halt_req, 32'h0);
		acc(1'b1, dhec_pkg::DHEC_OFS_CAUSE, 32'h0000_001F);
		core_ev = 5'h11;
		cyc(1);
		core_ev = 5'h00;
		wait_on(0);
		rd(dhec_pkg::DHEC_OFS_CAUSE, 32'h0000_0002, "cause_prio");
		core_st = 3'h1;
		cyc(3);
		core_st = 3'h0;
		acc(1'b1, dhec_pkg::DHEC_OFS_CAUSE, 32'h0000_001F);
		ext_hr = 1'b1;
		wait_on(0);
		rd(dhec_pkg::DHEC_OFS_CAUSE, 32'h0000_0010, "cause_ext");
		core_st = 3'h1;
		ext_hr = 1'b0;
		wait_on(1);
		core_st = 3'h0;
		cyc(3);
		acc(1'b1, dhec_pkg::DHEC_OFS_CAUSE, 32'h0000_001F);
	endtask : t_halt
	task automatic t_resets;
		hcs(4'h9);
		cyc(1);
		chk("mask", imask, 32'h1);
		warm_reset_n = 1'b0;
		cyc(2);
		warm_reset_n = 1'b1;
		rd(dhec_pkg::DHEC_OFS_HCS, 32'h0001_0009, "hcs_warm_reg");
		acc(1'b1, dhec_pkg::DHEC_OFS_PWR, 32'h0000_0000);
		cyc(2);
		warm_reset_n = 1'b0;
		cyc(2);
		warm_reset_n = 1'b1;
		rd(dhec_pkg::DHEC_OFS_HCS, 32'h0001_0000, "hcs_warm_unreg");
		chk("mask_off", imask, 32'h0);
		hcs(4'h9);
		acc(1'b1, dhec_pkg::DHEC_OFS_PWR, 32'h0000_0001);
		rst = 1'b1;
		cyc(2);
		rst = 1'b0;
		rd(dhec_pkg::DHEC_OFS_PWR, 32'h0000_0000, "pwr_por");
		rd(dhec_pkg::DHEC_OFS_HCS, 32'h0001_0000, "hcs_por");
	endtask : t_resets
	task automatic t_link;
		dhec_probe_i.one_pin_frame(8);
		rd(dhec_pkg::DHEC_OFS_PWR, 32'h0000_0008, "pwr_one_pin");
		core_st = 3'h2;
		hcs(4'h3);
		wait_on(0);
		cyc(2);
		chk("wake_deep_one_pin", wake_event, 32'h0);
		chk("swdio_oe_n", swdio_oe_n, 32'h1);
		chk("swdio_out", swdio_out, 32'h0);
		dhec_probe_i.two_wire_frame(8);
		wait_on(2);
		rd(dhec_pkg::DHEC_OFS_PWR, 32'h0000_000C, "pwr_two_wire");
	endtask : t_link

	initial begin
		cyc(4);
		rst = 1'b0;
		t_ident();
		t_events();
		t_halt();
		t_resets();
		t_link();
		finish_test();
	end
endmodule : tb_top
